/* File: hdl/axil_reg_slave.sv */
// AXI4-Lite slave front end: handshakes, register index and response words
`timescale 1ns/1ps
module axil_reg_slave (
  input  wire logic                   ref_clk_i,
  input  wire logic                   reset_n_i,
  input  temp_alert_pkg::axi_req_type axi_req_i,
  output temp_alert_pkg::axi_rsp_type axi_rsp_o,
  output logic                        wr_o,
  output logic [5:0]                  wr_idx_o,
  output logic [15:0]                 wr_data_o,
  output logic [1:0]                  wr_strb_o,
  output logic                        rd_o,
  output logic [5:0]                  rd_idx_o,
  input  wire logic [15:0]            rd_data_i
);

  typedef struct packed {
    logic        aw_have;
    logic [5:0]  aw_idx;
    logic        w_have;
    logic [15:0] wdata;
    logic [1:0]  wstrb;
    temp_alert_pkg::axi_rsp_type rsp;
  } axi_state_type;

  axi_state_type q;
  axi_state_type d;

  always_comb
  begin
    d         = q;
    wr_o      = q.aw_have && q.w_have && !q.rsp.bvalid;
    rd_o      = axi_req_i.arvalid && q.rsp.arready;
    rd_idx_o  = axi_req_i.araddr[7:2];
    wr_idx_o  = q.aw_idx;
    wr_data_o = q.wdata;
    wr_strb_o = q.wstrb;
    if (axi_req_i.awvalid && q.rsp.awready)
    begin
      d.aw_have = 1'b1;
      d.aw_idx  = axi_req_i.awaddr[7:2];
    end
    if (axi_req_i.wvalid && q.rsp.wready)
    begin
      d.w_have = 1'b1;
      d.wdata  = axi_req_i.wdata[15:0];
      d.wstrb  = axi_req_i.wstrb[1:0];
    end
    if (wr_o)
    begin
      d.aw_have    = 1'b0;
      d.w_have     = 1'b0;
      d.rsp.bvalid = 1'b1;
      d.rsp.bresp  = temp_alert_pkg::reg_mapped(q.aw_idx) ? temp_alert_pkg::RESP_OKAY
                                                          : temp_alert_pkg::RESP_SLVERR;
    end
    else if (q.rsp.bvalid && axi_req_i.bready)
    begin
      d.rsp.bvalid = 1'b0;
    end
    if (rd_o)
    begin
      d.rsp.rvalid = 1'b1;
      d.rsp.rdata  = {16'h0000, rd_data_i};
      d.rsp.rresp  = temp_alert_pkg::reg_mapped(rd_idx_o) ? temp_alert_pkg::RESP_OKAY
                                                          : temp_alert_pkg::RESP_SLVERR;
    end
    else if (q.rsp.rvalid && axi_req_i.rready)
    begin
      d.rsp.rvalid = 1'b0;
    end
    // One write and one read in flight; new addresses wait for the response
    d.rsp.awready = !d.aw_have && !d.rsp.bvalid;
    d.rsp.wready  = !d.w_have && !d.rsp.bvalid;
    d.rsp.arready = !d.rsp.rvalid;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
    begin
      q             <= '0;
      q.rsp.awready <= 1'b1;
      q.rsp.wready  <= 1'b1;
      q.rsp.arready <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  assign axi_rsp_o = q.rsp;

endmodule

/* File: hdl/quarter_ms_tick.sv */
// Free-running divider giving a one-cycle enable every tick period
`timescale 1ns/1ps
module quarter_ms_tick #(
  parameter int unsigned CYCLES = temp_alert_pkg::TICK_CYCLES
) (
  input  wire logic ref_clk_i,
  input  wire logic reset_n_i,
  input  wire logic clear_i,
  output logic      tick_o
);

  typedef struct packed {
    logic [31:0] cnt;
    logic        tick;
  } tick_state_type;

  tick_state_type q;
  tick_state_type d;

  always_comb
  begin
    d      = q;
    d.tick = 1'b0;
    if (clear_i)
    begin
      // The clearing cycle counts as the first of the new tick period
      d.cnt = 32'h1;
    end
    else if (q.cnt == CYCLES - 1)
    begin
      d.cnt  = 32'h0;
      d.tick = 1'b1;
    end
    else
    begin
      d.cnt = q.cnt + 32'h1;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign tick_o = q.tick;

endmodule

/* File: hdl/temp_alert_flags.sv */
// Alert flags, operation settings and conversion sequencing of the temperature sensor
//
// How it works
// - Upper flag sets on rising above upper limit or falling below limit minus hysteresis
// - After the upper flag sets, it re-arms only below upper limit minus hysteresis
// - Lower flag sets on falling below lower limit or rising above limit plus hysteresis
// - After the lower flag sets, it re-arms only above lower limit plus hysteresis
// - Fresh-result flag sets per result, clears on reading flags or temperature
// - Writing soft reset bit starts a 0.5 ms reset; bit reads zero
// - Averaging enabled makes every result, one-shot too, the mean of eight
// - Alert style bit: zero selects interrupt, one selects comparator behaviour
// - Writing one-shot bit runs one conversion group (eight with averaging) then enters shutdown; reads zero
// - Mode bit zero runs continuous conversions, one means shutdown
// - Interval field picks 6 ms up to 2 s, reset value 110b
// - Settings at index 03h, reset 0006h, reserved bits read zero
// - High and low flags clear only on a single, non-burst read of the flags word
// - Results and limits are 14-bit two's complement, step 0.03125 degC
// - Hysteresis values are 8-bit unsigned with a 0.5 degC step
`timescale 1ns/1ps
module temp_alert_flags #(
  parameter int unsigned TICK_CYCLES = temp_alert_pkg::TICK_CYCLES
) (
  input  wire logic                      ref_clk_i,
  input  wire logic                      reset_n_i,
  input  temp_alert_pkg::axi_req_type    axi_req_i,
  output temp_alert_pkg::axi_rsp_type    axi_rsp_o,
  input  temp_alert_pkg::thresholds_type thresholds_i,
  input  wire logic                      conv_done_i,
  input  wire logic [13:0]               conv_data_i,
  output logic                           conv_start_o,
  output logic                           alert_style_o,
  output logic                           soft_reset_active_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_WAIT
  } seq_type;

  typedef struct packed {
    logic        avg_en;
    logic        alert_style;
    logic        shutdown;
    logic [2:0]  period_sel;
    logic [13:0] result;
    logic        high_flag;
    logic        low_flag;
    logic        fresh_flag;
    logic        high_status;
    logic        low_status;
    seq_type     seq;
    logic [2:0]  grp_cnt;
    logic [16:0] acc;
    logic        grp_avg;
    logic        grp_one_shot;
    logic        one_shot_pend;
    logic [12:0] per_cnt;
    logic [1:0]  srst_cnt;
    logic        conv_start;
    logic        srst_active;
  } core_state_type;

  core_state_type q;
  core_state_type d;

  // ----------------------------------------------------------------
  // Bus front end and tick divider
  // ----------------------------------------------------------------
  logic        wr;
  logic [5:0]  wr_idx;
  logic [15:0] wr_data;
  logic [1:0]  wr_strb;
  logic        rd;
  logic [5:0]  rd_idx;
  logic [15:0] rd_data;
  logic        tick;
  logic        srst_req;

  axil_reg_slave u_bus (
    .ref_clk_i (ref_clk_i),
    .reset_n_i (reset_n_i),
    .axi_req_i (axi_req_i),
    .axi_rsp_o (axi_rsp_o),
    .wr_o      (wr),
    .wr_idx_o  (wr_idx),
    .wr_data_o (wr_data),
    .wr_strb_o (wr_strb),
    .rd_o      (rd),
    .rd_idx_o  (rd_idx),
    .rd_data_i (rd_data)
  );

  // Restarting the divider makes the reset hold exactly whole ticks
  quarter_ms_tick #(
    .CYCLES (TICK_CYCLES)
  ) u_tick (
    .ref_clk_i (ref_clk_i),
    .reset_n_i (reset_n_i),
    .clear_i   (srst_req),
    .tick_o    (tick)
  );

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_comb
  begin
    rd_data = 16'h0000;
    unique case (rd_idx)
      temp_alert_pkg::IDX_TEMP_RESULT:
      begin
        rd_data = {q.result, 2'b00};
      end
      temp_alert_pkg::IDX_ALERT_FLAGS:
      begin
        rd_data[temp_alert_pkg::BIT_HIGH_STATUS] = q.high_status;
        rd_data[temp_alert_pkg::BIT_LOW_STATUS]  = q.low_status;
        rd_data[temp_alert_pkg::BIT_HIGH_FLAG]   = q.high_flag;
        rd_data[temp_alert_pkg::BIT_LOW_FLAG]    = q.low_flag;
        rd_data[temp_alert_pkg::BIT_FRESH_FLAG]  = q.fresh_flag;
      end
      temp_alert_pkg::IDX_OP_SETTINGS:
      begin
        // Trigger bits and reserved bits always read zero
        rd_data[temp_alert_pkg::BIT_AVG_EN]      = q.avg_en;
        rd_data[temp_alert_pkg::BIT_ALERT_STYLE] = q.alert_style;
        rd_data[temp_alert_pkg::BIT_SHUTDOWN]    = q.shutdown;
        rd_data[2:0]                             = q.period_sel;
      end
      default:
      begin
        rd_data = 16'h0000;
      end
    endcase
  end

  assign srst_req = wr && (wr_idx == temp_alert_pkg::IDX_OP_SETTINGS) && wr_strb[1]
                    && wr_data[temp_alert_pkg::BIT_SOFT_RESET];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic               grp_done;
    logic [13:0]        res;
    logic signed [15:0] r16;
    logic signed [15:0] hi16;
    logic signed [15:0] lo16;
    logic signed [15:0] hi_rearm;
    logic signed [15:0] lo_rearm;
    logic               limits_ok;
    logic               hi_set;
    logic               lo_set;
    logic               launch;
    logic               wr_cfg;
    logic [16:0]        sum;
    d         = q;
    grp_done  = 1'b0;
    res       = q.result;
    r16       = '0;
    hi_set    = 1'b0;
    lo_set    = 1'b0;
    launch    = 1'b0;
    sum       = q.acc + {{3{conv_data_i[13]}}, conv_data_i};
    hi16      = 16'(signed'(thresholds_i.high_limit));
    lo16      = 16'(signed'(thresholds_i.low_limit));
    // One hysteresis step is sixteen result steps
    hi_rearm  = hi16 - signed'({4'h0, thresholds_i.high_hyst, 4'h0});
    lo_rearm  = lo16 + signed'({4'h0, thresholds_i.low_hyst, 4'h0});
    limits_ok = hi16 > lo16;
    wr_cfg    = wr && (wr_idx == temp_alert_pkg::IDX_OP_SETTINGS);
    d.conv_start = 1'b0;

    // Interval counter parks at zero while stopped, so leaving shutdown or
    // soft reset launches a conversion on the very next tick
    if (q.shutdown || (q.srst_cnt != 2'h0))
    begin
      d.per_cnt = 13'h0;
    end
    else if (tick)
    begin
      if (q.per_cnt == 13'h0)
      begin
        d.per_cnt = temp_alert_pkg::period_ticks(q.period_sel) - 13'h1;
        launch    = 1'b1;
      end
      else
      begin
        d.per_cnt = q.per_cnt - 13'h1;
      end
    end

    // Conversion sequencing, eight per group with averaging
    unique case (q.seq)
      SEQ_IDLE:
      begin
        if (q.one_shot_pend && (q.srst_cnt == 2'h0))
        begin
          d.one_shot_pend = 1'b0;
          d.grp_one_shot  = 1'b1;
          launch          = 1'b1;
        end
        else
        begin
          d.grp_one_shot = 1'b0;
        end
        if (launch)
        begin
          d.seq        = SEQ_WAIT;
          d.grp_cnt    = 3'h0;
          d.acc        = 17'h0;
          d.grp_avg    = q.avg_en;
          d.conv_start = 1'b1;
        end
      end
      SEQ_WAIT:
      begin
        if (conv_done_i)
        begin
          if (!q.grp_avg)
          begin
            grp_done = 1'b1;
            res      = conv_data_i;
            d.seq    = SEQ_IDLE;
          end
          else if (q.grp_cnt == 3'(temp_alert_pkg::AVG_COUNT - 1))
          begin
            grp_done = 1'b1;
            res      = sum[16:3];
            d.seq    = SEQ_IDLE;
          end
          else
          begin
            d.acc        = sum;
            d.grp_cnt    = q.grp_cnt + 3'h1;
            d.conv_start = 1'b1;
          end
        end
      end
    endcase

    // Flag evaluation happens only at the end of a group
    if (grp_done)
    begin
      d.result     = res;
      d.fresh_flag = 1'b1;
      r16          = 16'(signed'(res));
      // Equal or crossed limits are ignored until set up properly
      if (limits_ok)
      begin
        if (!q.high_status && (r16 > hi16))
        begin
          d.high_status = 1'b1;
          hi_set        = 1'b1;
        end
        else if (q.high_status && (r16 < hi_rearm))
        begin
          d.high_status = 1'b0;
          hi_set        = 1'b1;
        end
        if (!q.low_status && (r16 < lo16))
        begin
          d.low_status = 1'b1;
          lo_set       = 1'b1;
        end
        else if (q.low_status && (r16 > lo_rearm))
        begin
          d.low_status = 1'b0;
          lo_set       = 1'b1;
        end
      end
      if (q.grp_one_shot)
      begin
        d.shutdown = 1'b1;
      end
    end

    // Read side effects; a flag set in the same cycle survives the clear
    if (rd && (rd_idx == temp_alert_pkg::IDX_ALERT_FLAGS))
    begin
      d.high_flag = 1'b0;
      d.low_flag  = 1'b0;
      if (!grp_done)
      begin
        d.fresh_flag = 1'b0;
      end
    end
    if (rd && (rd_idx == temp_alert_pkg::IDX_TEMP_RESULT) && !grp_done)
    begin
      d.fresh_flag = 1'b0;
    end
    if (hi_set)
    begin
      d.high_flag = 1'b1;
    end
    if (lo_set)
    begin
      d.low_flag = 1'b1;
    end

    // Settings writes, byte lanes honoured
    if (wr_cfg && wr_strb[0])
    begin
      d.avg_en      = wr_data[temp_alert_pkg::BIT_AVG_EN];
      d.alert_style = wr_data[temp_alert_pkg::BIT_ALERT_STYLE];
      d.shutdown    = wr_data[temp_alert_pkg::BIT_SHUTDOWN];
      d.period_sel  = wr_data[2:0];
      if (wr_data[temp_alert_pkg::BIT_ONE_SHOT])
      begin
        d.one_shot_pend = 1'b1;
      end
    end

    // Soft reset: everything back to reset values, then hold for the reset time
    if (srst_req)
    begin
      d            = '0;
      d.period_sel = temp_alert_pkg::PERIOD_RST;
      d.seq        = SEQ_IDLE;
      d.srst_cnt   = 2'(temp_alert_pkg::SRST_TICKS);
    end
    else if (tick && (q.srst_cnt != 2'h0))
    begin
      d.srst_cnt = q.srst_cnt - 2'h1;
    end
    d.srst_active = d.srst_cnt != 2'h0;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
    begin
      q            <= '0;
      q.period_sel <= temp_alert_pkg::PERIOD_RST;
      q.seq        <= SEQ_IDLE;
    end
    else
    begin
      q <= d;
    end
  end

  // Style only leaves the block; the alert pin logic lives elsewhere
  assign alert_style_o       = q.alert_style;
  assign conv_start_o        = q.conv_start;
  assign soft_reset_active_o = q.srst_active;

endmodule

/* File: hdl/temp_alert_pkg.sv */
// Shared constants, bus carriers and helper functions of the temperature alert block
package temp_alert_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned TICK_TIME_NS   = 250000;
  localparam int unsigned TICK_CYCLES    = (TICK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SRST_TIME_NS   = 500000;
  localparam int unsigned SRST_TICKS     = SRST_TIME_NS / TICK_TIME_NS;
  // Conversion periods, 000b up to 111b, in ns
  localparam int unsigned PERIOD_NS [8] = '{6000000, 31250000, 62500000, 125000000,
                                            250000000, 500000000, 1000000000, 2000000000};

  // ----------------------------------------------------------------
  // Register map: printed offsets are indices, byte address is 4x
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_TEMP_RESULT  = 6'h00;
  localparam logic [5:0] IDX_ALERT_FLAGS  = 6'h02;
  localparam logic [5:0] IDX_OP_SETTINGS  = 6'h03;
  localparam int unsigned BIT_SOFT_RESET  = 8;
  localparam int unsigned BIT_AVG_EN      = 7;
  localparam int unsigned BIT_ALERT_STYLE = 5;
  localparam int unsigned BIT_ONE_SHOT    = 4;
  localparam int unsigned BIT_SHUTDOWN    = 3;
  localparam int unsigned BIT_HIGH_STATUS = 4;
  localparam int unsigned BIT_LOW_STATUS  = 3;
  localparam int unsigned BIT_HIGH_FLAG   = 2;
  localparam int unsigned BIT_LOW_FLAG    = 1;
  localparam int unsigned BIT_FRESH_FLAG  = 0;
  localparam logic [2:0]  PERIOD_RST      = 3'h6;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;
  localparam int unsigned AVG_COUNT       = 8;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [7:0]  araddr;
    logic        arvalid;
    logic        rready;
  } axi_req_type;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
  } axi_rsp_type;

  typedef struct packed {
    logic [13:0] high_limit;
    logic [13:0] low_limit;
    logic [7:0]  high_hyst;
    logic [7:0]  low_hyst;
  } thresholds_type;

  function automatic logic reg_mapped(input logic [5:0] idx);
    return (idx == IDX_TEMP_RESULT) || (idx == IDX_ALERT_FLAGS) || (idx == IDX_OP_SETTINGS);
  endfunction

  function automatic logic [12:0] period_ticks(input logic [2:0] sel);
    return 13'(PERIOD_NS[sel] / TICK_TIME_NS);
  endfunction

endpackage

/* File: testbench/conv_model.sv */
// Behavioural converter model answering conversion requests
`timescale 1ns/1ps
module conv_model (
  input  wire logic        ref_clk_i,
  input  wire logic        conv_start_i,
  input  int               delay_i,
  input  wire logic [13:0] base_i,
  output logic             conv_done_o,
  output logic [13:0]      conv_data_o,
  output int               starts_o
);
  logic [2:0] k;

  // Results step through base..base+7, so any eight in a row average to base+3
  initial
  begin
    conv_done_o = 1'b0;
    conv_data_o = 14'h0;
    starts_o = 0;
    k = 3'h0;
    forever
    begin
      @(negedge ref_clk_i);
      if (conv_start_i)
      begin
        starts_o++;
        repeat (delay_i) @(posedge ref_clk_i);
        conv_done_o <= 1'b1;
        conv_data_o <= base_i + 14'(k);
        k++;
        @(posedge ref_clk_i);
        conv_done_o <= 1'b0;
        // Data is not held after the pulse: show the inverse
        conv_data_o <= ~conv_data_o;
      end
    end
  end
endmodule

/* File: testbench/tb.sv */
// Self-checking bench for the temperature alert block
`timescale 1ns/1ps
module tb;
  localparam int unsigned TC = 20;
  logic                           ref_clk_i;
  logic                           reset_n_i;
  temp_alert_pkg::axi_req_type    req;
  temp_alert_pkg::axi_rsp_type    rsp;
  temp_alert_pkg::thresholds_type thr;
  logic                           done;
  logic [13:0]                    cdata;
  logic                           start;
  logic                           style;
  logic                           srst;
  logic [13:0]                    base;
  logic [31:0]                    rd;
  logic [1:0]                     resp;
  int                             mismatches = 0;
  int                             num_checks = 0;
  int                             cycles = 0;
  int                             dly;
  int                             starts;
  int                             s0;
  time                            tt;
  // Conversion periods of codes 000..010 in quarter-ms ticks
  int                             per [3] = '{24, 125, 250};

  temp_alert_flags #(.TICK_CYCLES(TC)) i_dut (.ref_clk_i, .reset_n_i, .axi_req_i(req),
    .axi_rsp_o(rsp), .thresholds_i(thr), .conv_done_i(done), .conv_data_i(cdata),
    .conv_start_o(start), .alert_style_o(style), .soft_reset_active_o(srst));
  conv_model i_conv (.ref_clk_i, .conv_start_i(start), .delay_i(dly), .base_i(base),
    .conv_done_o(done), .conv_data_o(cdata), .starts_o(starts));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    if (mismatches == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Each channel is sampled and released at the rising edge that takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic aw_t;
    logic w_t;
    logic b_t;
    @(posedge ref_clk_i);
    req.awaddr <= a;
    req.awvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= s;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    forever
    begin
      @(posedge ref_clk_i);
      aw_t = req.awvalid && rsp.awready;
      w_t = req.wvalid && rsp.wready;
      b_t = rsp.bvalid;
      resp = rsp.bresp;
      if (aw_t) req.awvalid <= 1'b0;
      if (w_t) req.wvalid <= 1'b0;
      if (b_t)
      begin
        req.bready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic rdr(input logic [7:0] a);
    logic ar_t;
    logic r_t;
    @(posedge ref_clk_i);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    forever
    begin
      @(posedge ref_clk_i);
      ar_t = req.arvalid && rsp.arready;
      r_t = rsp.rvalid;
      rd = rsp.rdata;
      resp = rsp.rresp;
      if (ar_t) req.arvalid <= 1'b0;
      if (r_t)
      begin
        req.rready <= 1'b0;
        break;
      end
    end
  endtask

  // One averaged one-shot, then flags, result and settings are read back
  task automatic shot(input logic [13:0] b, input logic [31:0] ef, input logic tf);
    s0 = starts;
    base <= b;
    dly <= b[1] ? 9 : 2;
    wr(8'h0c, 32'h0000_00b8, 4'h1);
    while (starts != s0 + 8) @(posedge ref_clk_i);
    repeat (40) @(posedge ref_clk_i);
    chk(32'(starts), 32'(s0 + 8));
    if (tf) rdr(8'h00);
    rdr(8'h08);
    chk(rd, ef);
    rdr(8'h00);
    chk(rd, {16'h0, b + 14'd3, 2'b00});
    rdr(8'h0c);
    chk(rd, 32'h0000_00a8);
  endtask

  // ----------------------------------------------------------------
  // Clock, timeout and test sequence
  // ----------------------------------------------------------------
  initial
  begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  always @(posedge ref_clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      mismatches++;
      report_and_stop();
    end
  end

  initial
  begin
    reset_n_i = 1'b0;
    req = '0;
    thr = {14'h0064, 14'h3f9c, 8'h01, 8'h01};
    base = 14'h0;
    dly = 2;
    repeat (16) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    rdr(8'h0c);
    chk(rd, 32'h0000_0006);
    wr(8'h0c, 32'h0000_ffe8, 4'h1);
    rdr(8'h0c);
    chk(rd, 32'h0000_00a8);
    chk(32'(style), 32'h1);
    repeat (100) @(posedge ref_clk_i);
    s0 = starts;
    repeat (600) @(posedge ref_clk_i);
    chk(32'(starts), 32'(s0));
    rdr(8'h08);
    rdr(8'h00);
    shot(14'h00c8, 32'h15, 1'b0);
    shot(14'h005a, 32'h11, 1'b0);
    shot(14'h003c, 32'h05, 1'b0);
    shot(14'h00c8, 32'h15, 1'b0);
    shot(14'h3f38, 32'h0f, 1'b0);
    shot(14'h3fa6, 32'h09, 1'b0);
    shot(14'h3fce, 32'h03, 1'b0);
    shot(14'h3fce, 32'h00, 1'b1);
    rdr(8'h04);
    chk(rd, 32'h0);
    chk(32'(resp), 32'(temp_alert_pkg::RESP_SLVERR));
    wr(8'h10, 32'h1, 4'h1);
    chk(32'(resp), 32'(temp_alert_pkg::RESP_SLVERR));
    wr(8'h0c, 32'h0000_0100, 4'h2);
    while (srst) @(posedge ref_clk_i);
    rdr(8'h0c);
    chk(rd, 32'h0000_0006);
    chk(32'(style), 32'h0);
    for (int p = 0; p < 3; p++)
    begin
      wr(8'h0c, 32'h0000_0008, 4'h1);
      repeat (40) @(posedge ref_clk_i);
      s0 = starts;
      wr(8'h0c, 32'(p), 4'h1);
      while (starts == s0) @(posedge ref_clk_i);
      tt = $time;
      while (starts == s0 + 1) @(posedge ref_clk_i);
      chk(32'(($time - tt) / 10), 32'(per[p] * TC));
    end
    report_and_stop();
  end
endmodule

/* File: testbench/temp_alert_checker.sv */
// Port-level assertions for the temperature alert block
`timescale 1ns/1ps
module temp_alert_checker #(
  parameter int unsigned TICK_CYCLES = 20
) (
  input  wire logic                      ref_clk_i,
  input  wire logic                      reset_n_i,
  input  temp_alert_pkg::axi_req_type    axi_req_i,
  input  temp_alert_pkg::axi_rsp_type    axi_rsp_o,
  input  temp_alert_pkg::thresholds_type thresholds_i,
  input  wire logic                      conv_done_i,
  input  wire logic [13:0]               conv_data_i,
  input  wire logic                      conv_start_o,
  input  wire logic                      alert_style_o,
  input  wire logic                      soft_reset_active_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);

  logic [31:0] srst_cnt_q;
  logic [7:0]  wr_addr_q;
  logic        wr_srst_q;
  logic        wr_low_q;
  logic        wr_style_q;
  logic        ar_go;
  assign ar_go = axi_req_i.arvalid && axi_rsp_o.arready;

  // ----------------------------------------------------------------
  // Helper state
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i)
  begin
    srst_cnt_q <= (reset_n_i && soft_reset_active_o) ? srst_cnt_q + 32'h1 : 32'h0;
    if (axi_req_i.awvalid && axi_rsp_o.awready)
      wr_addr_q <= axi_req_i.awaddr;
    if (axi_req_i.wvalid && axi_rsp_o.wready)
    begin
      wr_srst_q <= axi_req_i.wstrb[1] && axi_req_i.wdata[8];
      wr_low_q <= axi_req_i.wstrb[0];
      wr_style_q <= axi_req_i.wdata[5];
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_srst_length: assert property ($fell(soft_reset_active_o) |->
    srst_cnt_q == 32'(2 * TICK_CYCLES)) else $error("soft reset length wrong");
  a_srst_no_start: assert property (soft_reset_active_o |-> !conv_start_o)
    else $error("conversion started during soft reset");
  a_start_single: assert property (conv_start_o |=> !conv_start_o)
    else $error("start pulse longer than one cycle");
  a_style_write: assert property (axi_rsp_o.bvalid && axi_req_i.bready &&
    wr_addr_q == 8'h0c && (wr_srst_q || wr_low_q) |=> alert_style_o == (wr_style_q && !wr_srst_q))
    else $error("alert style output not following write");
  a_cfg_reserved: assert property (ar_go && axi_req_i.araddr == 8'h0c |=>
    axi_rsp_o.rvalid && axi_rsp_o.rdata[31:8] == 24'h0 && !axi_rsp_o.rdata[6] &&
    !axi_rsp_o.rdata[4]) else $error("settings reserved or trigger bits not zero");
  a_cfg_style: assert property (ar_go && axi_req_i.araddr == 8'h0c |=>
    axi_rsp_o.rdata[5] == alert_style_o) else $error("style bit differs from output");
  a_temp_format: assert property (ar_go && axi_req_i.araddr == 8'h00 |=>
    axi_rsp_o.rdata[31:16] == 16'h0 && axi_rsp_o.rdata[1:0] == 2'h0)
    else $error("result word format wrong");
  a_flags_upper: assert property (ar_go && axi_req_i.araddr == 8'h08 |=>
    axi_rsp_o.rdata[31:5] == 27'h0) else $error("flags word upper bits set");
  a_unmapped_err: assert property (ar_go && !(axi_req_i.araddr[7:2] inside {6'h0, 6'h2, 6'h3})
    |=> axi_rsp_o.rresp == 2'h2 && axi_rsp_o.rdata == 32'h0)
    else $error("unmapped read not refused");

  c_srst: cover property ($fell(soft_reset_active_o));
  c_avg_chain: cover property (conv_done_i ##1 conv_start_o);
  c_unmapped: cover property (ar_go && axi_req_i.araddr == 8'h04);
endmodule

bind temp_alert_flags temp_alert_checker #(.TICK_CYCLES(TICK_CYCLES)) i_chk (
  .ref_clk_i, .reset_n_i, .axi_req_i, .axi_rsp_o, .thresholds_i, .conv_done_i,
  .conv_data_i, .conv_start_o, .alert_style_o, .soft_reset_active_o);
